//--- gtm_pkg.sv
/*
 gtm_pkg: constants and carrier types for the gated 16-bit timer.
 assumes a single 125 MHz clock and plain-port software access.
*/
package gtm_pkg;
    localparam int GTM_SRC_COUNT = 4;
    localparam int GTM_SEL_W = 2;
    localparam logic [7:0] GTM_BYTE_RESET = 8'h00;
    localparam logic [15:0] GTM_COUNT_RESET = 16'h0000;
    localparam logic [15:0] GTM_COUNT_STEP = 16'h0001;
    localparam int GTM_CTRL_ATOMIC_POS = 0;
    localparam int GTM_GATE_ENABLE_POS = 0;
    localparam int GTM_GATE_POL_POS = 1;

    // one software access to the count bytes
    typedef struct packed {
        logic rd_low;
        logic rd_high;
        logic wr_low;
        logic wr_high;
        logic [7:0] wdata;
    } gtm_access_t;

    // gate configuration
    typedef struct packed {
        logic gate_mode_enable;
        logic gate_polarity;
        logic [GTM_SEL_W-1:0] gate_select;
    } gtm_gate_cfg_t;

    typedef enum logic [1:0] {
        GTM_IDLE = 2'b00,
        GTM_COUNT = 2'b01,
        GTM_HOLD = 2'b10
    } gtm_state_t;
endpackage

//--- gtm_timer.sv
/*
 gtm_timer: 16-bit counter with atomic byte access and a gated enable.
 assumes the gate sources and timer clock source arrive asynchronously;
 software strobes are synchronous one-cycle pulses on clock.
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - atomic access mode turns on with the control bit
// - in atomic mode the high byte is reached only via buffer
// - low byte read in atomic mode copies live high byte into the buffer
// - high byte read in atomic mode returns the buffer
// - low byte write in atomic mode loads buffer into high byte at once
// - low byte write clears prescaler; high byte write does not
// - without atomic mode both bytes are accessed directly
// - counter runs freely or is gated when gate mode is on
// - polarity bit picks active gate level
// - count on clock source rising edge while gate is active
// - gate signal chosen from several sources
module gtm_timer (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic atomic_access_enable,
    input wire gtm_pkg::gtm_gate_cfg_t gate_cfg,
    input wire logic [gtm_pkg::GTM_SRC_COUNT-1:0] gate_sources,
    input wire logic timer_clock_source,
    input wire gtm_pkg::gtm_access_t access,
    output logic [7:0] rdata,
    output logic rdata_valid,
    output logic [15:0] count,
    output logic prescaler_clear,
    output logic gate_signal,
    output logic counting
);
    import gtm_pkg::*;

    logic [GTM_SRC_COUNT-1:0] src_meta;
    logic [GTM_SRC_COUNT-1:0] src_sync;
    logic tclk_meta;
    logic tclk_sync;
    logic tclk_prev;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] high_buffer;
    logic gate_active;
    logic tick;
    logic run;
    gtm_state_t state;

    // pick the selected gate source
    function automatic logic gate_pick(
        input logic [GTM_SRC_COUNT-1:0] src,
        input logic [GTM_SEL_W-1:0] sel
    );
        gate_pick = src[sel];
    endfunction

    // two-flop synchronisers for pin inputs
    genvar g;
    generate
        for (g = 0; g < GTM_SRC_COUNT; g++) begin : g_sync
            always_ff @(posedge clock) begin
                if (rst) begin
                    src_meta[g] <= 1'b0;
                    src_sync[g] <= 1'b0;
                end else if (clk_en) begin
                    src_meta[g] <= gate_sources[g];
                    src_sync[g] <= src_meta[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (rst) begin
            tclk_meta <= 1'b0;
            tclk_sync <= 1'b0;
            tclk_prev <= 1'b0;
        end else if (clk_en) begin
            tclk_meta <= timer_clock_source;
            tclk_sync <= tclk_meta;
            tclk_prev <= tclk_sync;
        end
    end

    always_comb begin
        gate_active = gate_pick(src_sync, gate_cfg.gate_select);
        tick = tclk_sync & ~tclk_prev;
        run = ~gate_cfg.gate_mode_enable |
              (gate_active == gate_cfg.gate_polarity);
    end

    // counter and high-byte buffer
    always_ff @(posedge clock) begin
        if (rst) begin
            count_low_byte <= GTM_BYTE_RESET;
            count_high_byte <= GTM_BYTE_RESET;
            high_buffer <= GTM_BYTE_RESET;
        end else if (clk_en) begin
            if (access.wr_low) begin
                count_low_byte <= access.wdata;
                if (atomic_access_enable) begin
                    count_high_byte <= high_buffer;
                end
            end else if (access.wr_high && !atomic_access_enable) begin
                count_high_byte <= access.wdata;
            end else if (tick && run) begin
                {count_high_byte, count_low_byte} <=
                    {count_high_byte, count_low_byte} + GTM_COUNT_STEP;
            end
            if (access.wr_high && atomic_access_enable) begin
                high_buffer <= access.wdata;
            end else if (access.rd_low && atomic_access_enable) begin
                high_buffer <= count_high_byte;
            end
        end
    end

    // read data
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata <= GTM_BYTE_RESET;
            rdata_valid <= 1'b0;
        end else if (clk_en) begin
            rdata_valid <= access.rd_low | access.rd_high;
            if (access.rd_low) begin
                rdata <= count_low_byte;
            end else if (access.rd_high) begin
                rdata <= atomic_access_enable ? high_buffer
                                              : count_high_byte;
            end
        end
    end

    // status outputs
    always_ff @(posedge clock) begin
        if (rst) begin
            prescaler_clear <= 1'b0;
            gate_signal <= 1'b0;
            counting <= 1'b0;
            count <= GTM_COUNT_RESET;
        end else if (clk_en) begin
            prescaler_clear <= access.wr_low;
            gate_signal <= gate_active;
            counting <= (state == GTM_COUNT);
            count <= {count_high_byte, count_low_byte};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= GTM_IDLE;
        end else if (clk_en) begin
            case (state)
                GTM_IDLE: state <= run ? GTM_COUNT : GTM_HOLD;
                GTM_COUNT: state <= run ? GTM_COUNT : GTM_HOLD;
                GTM_HOLD: state <= run ? GTM_COUNT : GTM_HOLD;
                default: state <= GTM_IDLE;
            endcase
        end
    end

    // assertions
    sequence s_low_read_atomic;
        access.rd_low && atomic_access_enable && clk_en && !access.wr_high;
    endsequence

    sequence s_high_read_atomic;
        access.rd_high && !access.rd_low && atomic_access_enable && clk_en;
    endsequence

    sequence s_free_tick;
        clk_en && tick && !gate_cfg.gate_mode_enable && !access.wr_low &&
        !access.wr_high;
    endsequence

    sequence s_gate_open;
        clk_en && tick && gate_cfg.gate_mode_enable &&
        gate_active == gate_cfg.gate_polarity && !access.wr_low &&
        !access.wr_high;
    endsequence

    a_buffer_capture: assert property (@(posedge clock) disable iff (rst)
        s_low_read_atomic |=> high_buffer == $past(count_high_byte))
        else $error("buffer missed high byte on low read");

    a_atomic_load: assert property (@(posedge clock) disable iff (rst)
        (access.wr_low && atomic_access_enable && clk_en) |=>
        count_high_byte == $past(high_buffer))
        else $error("high byte not loaded from buffer");

    a_high_read_buf: assert property (@(posedge clock) disable iff (rst)
        (access.rd_high && !access.rd_low && atomic_access_enable && clk_en)
        |=> rdata == $past(high_buffer))
        else $error("atomic high read not from buffer");

    a_high_protect: assert property (@(posedge clock) disable iff (rst)
        (access.wr_high && atomic_access_enable && !access.wr_low &&
         !(tick && run)) |=> $stable(count_high_byte))
        else $error("high byte written directly in atomic mode");

    a_direct_high: assert property (@(posedge clock) disable iff (rst)
        (access.wr_high && !access.wr_low && !atomic_access_enable && clk_en)
        |=> count_high_byte == $past(access.wdata))
        else $error("direct high write lost");

    a_prescale_clr: assert property (@(posedge clock) disable iff (rst)
        clk_en |=> prescaler_clear == $past(access.wr_low))
        else $error("prescaler clear mismatch");

    a_gate_hold: assert property (@(posedge clock) disable iff (rst)
        (clk_en && gate_cfg.gate_mode_enable &&
         gate_active != gate_cfg.gate_polarity && !access.wr_low &&
         !access.wr_high) |=> $stable({count_high_byte, count_low_byte}))
        else $error("count moved while gate inactive");

    a_count_step: assert property (@(posedge clock) disable iff (rst)
        (clk_en && tick && run && !access.wr_low && !access.wr_high) |=>
        {count_high_byte, count_low_byte} ==
        $past({count_high_byte, count_low_byte}) + GTM_COUNT_STEP)
        else $error("counter did not step by one");

    a_free_run: assert property (@(posedge clock) disable iff (rst)
        s_free_tick |=> {count_high_byte, count_low_byte} ==
        $past({count_high_byte, count_low_byte}) + GTM_COUNT_STEP)
        else $error("free run blocked");

    a_gate_select: assert property (@(posedge clock) disable iff (rst)
        clk_en |=> gate_signal == $past(src_sync[gate_cfg.gate_select]))
        else $error("gate select wrong");

    a_gate_count: assert property (@(posedge clock) disable iff (rst)
        s_gate_open |=> {count_high_byte, count_low_byte} ==
        $past({count_high_byte, count_low_byte}) + GTM_COUNT_STEP)
        else $error("count held while gate active");

    a_atomic_pair: assert property (@(posedge clock) disable iff (rst)
        s_low_read_atomic ##1 !(access.wr_high || access.rd_low) ##1
        s_high_read_atomic |=> rdata == $past(count_high_byte, 3))
        else $error("atomic pair not from one instant");

    a_read_valid: assert property (@(posedge clock) disable iff (rst)
        clk_en |=> rdata_valid == $past(access.rd_low || access.rd_high))
        else $error("read valid pulse wrong");

    a_low_read: assert property (@(posedge clock) disable iff (rst)
        (clk_en && access.rd_low) |=> rdata == $past(count_low_byte))
        else $error("low byte read wrong");

    a_direct_read: assert property (@(posedge clock) disable iff (rst)
        (clk_en && access.rd_high && !access.rd_low && !atomic_access_enable)
        |=> rdata == $past(count_high_byte))
        else $error("direct high read wrong");

    a_rdata_hold: assert property (@(posedge clock) disable iff (rst)
        !(clk_en && (access.rd_low || access.rd_high)) |=> $stable(rdata))
        else $error("read data changed without a read");

    a_low_write: assert property (@(posedge clock) disable iff (rst)
        (clk_en && access.wr_low) |=> count_low_byte == $past(access.wdata))
        else $error("low byte write lost");

    a_buffer_write: assert property (@(posedge clock) disable iff (rst)
        (clk_en && access.wr_high && atomic_access_enable) |=>
        high_buffer == $past(access.wdata))
        else $error("buffer write lost");

    a_high_no_clear: assert property (@(posedge clock) disable iff (rst)
        (clk_en && access.wr_high && !access.wr_low) |=> !prescaler_clear)
        else $error("high write cleared prescaler");

    a_no_tick_hold: assert property (@(posedge clock) disable iff (rst)
        (clk_en && !tick && !access.wr_low && !access.wr_high) |=>
        $stable({count_high_byte, count_low_byte}))
        else $error("count moved without a clock edge");

    a_wrap_zero: assert property (@(posedge clock) disable iff (rst)
        (clk_en && tick && run && !access.wr_low && !access.wr_high &&
         &{count_high_byte, count_low_byte}) |=>
        {count_high_byte, count_low_byte} == GTM_COUNT_RESET)
        else $error("counter did not wrap to zero");

    a_reset_zero: assert property (@(posedge clock)
        rst |=> {count_high_byte, count_low_byte} == GTM_COUNT_RESET &&
        count == GTM_COUNT_RESET && high_buffer == GTM_BYTE_RESET &&
        !rdata_valid && !prescaler_clear)
        else $error("reset values wrong");

    a_counting: assert property (@(posedge clock) disable iff (rst)
        clk_en ##1 clk_en |=> counting == $past(run, 2))
        else $error("counting status wrong");

    a_count_out: assert property (@(posedge clock) disable iff (rst)
        clk_en |=> count == $past({count_high_byte, count_low_byte}))
        else $error("count output stale");

    a_freeze: assert property (@(posedge clock) disable iff (rst)
        !clk_en |=> $stable({count_high_byte, count_low_byte, high_buffer,
        rdata, count, state}))
        else $error("state moved while clock enable low");
endmodule
`default_nettype wire

//--- gated_timer_16bit_access_tb.sv
/*
 gated_timer_16bit_access_tb: self-checking bench for gtm_timer.
 assumes the gtm_pkg package; counts are compared with an integer model.
*/
`timescale 1ns/1ps
`default_nettype none
module gated_timer_16bit_access_tb;
    import gtm_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic atomic_access_enable = 1'b0;
    gtm_gate_cfg_t gate_cfg = '0;
    logic [GTM_SRC_COUNT-1:0] gate_sources = '0;
    logic timer_clock_source = 1'b0;
    gtm_access_t access = '0;
    logic [7:0] rdata;
    logic rdata_valid;
    logic [15:0] count;
    logic prescaler_clear;
    logic gate_signal;
    logic counting;
    logic pc_seen;
    logic act;
    int failures = 0;
    int comparisons = 0;
    int seed = 4;
    int exp_count = 0;
    int k;

    initial begin
        forever #4 clock = ~clock;
    end

    gtm_timer u_gtm_timer (.clock(clock), .rst(rst), .clk_en(clk_en),
        .atomic_access_enable(atomic_access_enable), .gate_cfg(gate_cfg),
        .gate_sources(gate_sources), .timer_clock_source(timer_clock_source),
        .access(access), .rdata(rdata), .rdata_valid(rdata_valid),
        .count(count), .prescaler_clear(prescaler_clear),
        .gate_signal(gate_signal), .counting(counting));

    task check(input string what, input logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task finish_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // kind 0 rd_low, 1 rd_high, 2 wr_low, 3 wr_high
    task strobe(input int kind, input logic [7:0] d);
        @(negedge clock);
        access = gtm_access_t'({4'b1000 >> kind, d});
        @(negedge clock);
        access = '0;
        pc_seen = prescaler_clear;
    endtask

    task rd(input int kind, input logic [7:0] exp);
        strobe(kind, 8'h00);
        check("rdata_valid", 16'h0001, {15'h0000, rdata_valid});
        check("rdata", {8'h00, exp}, {8'h00, rdata});
    endtask

    task tick(input bit active);
        @(negedge clock);
        timer_clock_source = 1'b1;
        repeat (4) @(negedge clock);
        timer_clock_source = 1'b0;
        repeat (4) @(negedge clock);
        exp_count = (exp_count + int'(active)) & 32'h0000ffff;
    endtask

    task settle;
        for (int i = 0; i < 20 && count !== exp_count[15:0]; i++)
            @(negedge clock);
        check("count", exp_count[15:0], count);
        if (count !== exp_count[15:0])
            finish_test();
    endtask

    initial begin
        repeat (20) @(negedge clock);
        rst = 1'b0;
        check("count after reset", 16'h0000, count);
        atomic_access_enable = 1'b1;
        strobe(3, 8'hab);
        check("clear on high write", 16'h0000, {15'h0, pc_seen});
        repeat (4) @(negedge clock);
        check("high kept", 16'h0000, count);
        strobe(2, 8'hcd);
        check("clear on low write", 16'h0001, {15'h0, pc_seen});
        exp_count = 32'h0000abcd;
        settle();
        $display("atomic write test done");
        strobe(3, 8'h00);
        strobe(2, 8'hff);
        exp_count = 32'h000000ff;
        settle();
        rd(0, 8'hff);
        tick(1'b1);
        settle();
        rd(1, 8'h00);
        atomic_access_enable = 1'b0;
        rd(1, 8'h01);
        strobe(3, 8'h12);
        exp_count = 32'h00001200;
        settle();
        $display("atomic read test done");
        atomic_access_enable = 1'b1;
        strobe(3, 8'hff);
        strobe(2, 8'hff);
        exp_count = 32'h0000ffff;
        settle();
        tick(1'b1);
        settle();
        clk_en = 1'b0;
        strobe(2, 8'h55);
        clk_en = 1'b1;
        repeat (4) @(negedge clock);
        settle();
        $display("wrap test done");
        strobe(3, 8'h34);
        strobe(2, 8'h56);
        exp_count = 32'h00003456;
        settle();
        rd(0, 8'h56);
        rd(1, 8'h34);
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        exp_count = 0;
        settle();
        rd(1, 8'h00);
        $display("reset test done");
        for (k = 0; k < 32; k++) begin
            gate_cfg = gtm_gate_cfg_t'(k[3:0]);
            gate_sources = GTM_SRC_COUNT'($random(seed));
            repeat (5) @(negedge clock);
            check("gate_signal", {15'h0, gate_sources[gate_cfg.gate_select]},
                {15'h0, gate_signal});
            act = !gate_cfg.gate_mode_enable ||
                gate_sources[gate_cfg.gate_select] == gate_cfg.gate_polarity;
            check("counting", {15'h0, act}, {15'h0, counting});
            tick(act);
            settle();
        end
        $display("gate test done");
        finish_test();
    end
endmodule
`default_nettype wire
